// >>> verilog/iofl_map.svh
/*
  Address map, reset values and timing counts of the industrial I/O fault latch.
  Assumes a 25 MHz reference clock and a four-location chip-select window.
*/
`ifndef IOFL_MAP_SVH
`define IOFL_MAP_SVH

`define IOFL_OFS_FAULT_STATUS 2'h2
`define IOFL_OFS_FAULT_CLEAR 2'h3
`define IOFL_FAULT_LSB 0
`define IOFL_FAULT_MSB 3

`define IOFL_FAULT_RST 4'hf
`define IOFL_FIELD_RST 24'hff_ffff
`define IOFL_RELAY_RST 8'h00
`define IOFL_HS_RST 8'hff
`define IOFL_HS_NIB_RST 4'hf
`define IOFL_FIELD_IDLE 24'h00_0000
`define IOFL_PWM_RST 2'h3

`define IOFL_CLK_KHZ 25000
`define IOFL_BLANK_TIME_US 1000
`define IOFL_DETECT_MAX_US 5000
`define IOFL_BLANK_CYCLES ((`IOFL_BLANK_TIME_US * `IOFL_CLK_KHZ + 999) / 1000)
`define IOFL_DETECT_MAX_CYCLES ((`IOFL_DETECT_MAX_US * `IOFL_CLK_KHZ) / 1000)
`define IOFL_CNT_W 15
`define IOFL_SYNC_LAT 2
`define IOFL_SETTLE_DONE 2'h3

`endif

// >>> verilog/iofl_pkg.sv
/*
  Types shared by the fault latch top and its detector.
  Assumes iofl_map.svh is on the include path.
*/
`include "iofl_map.svh"

package iofl_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_STATUS,
    ACC_CLEAR,
    ACC_OTHER
  } iofl_acc_t;

  typedef struct packed {
    logic [23:0] fin_s1;
    logic [23:0] fin_s2;
    logic [23:0] fin_q;
    logic [7:0] rly_s1;
    logic [7:0] rly_s2;
    logic [3:0] p3_s1;
    logic [3:0] p3_s2;
    logic [3:0] p7_s1;
    logic [3:0] p7_s2;
    logic [1:0] pwm_s1;
    logic [1:0] pwm_s2;
    logic [3:0] sc_s1;
    logic [3:0] sc_s2;
    logic [3:0] ol_s1;
    logic [3:0] ol_s2;
    logic olen_s1;
    logic olen_s2;
    logic cs_s1;
    logic cs_s2;
    logic rd_s1;
    logic rd_s2;
    logic [1:0] addr_s1;
    logic [1:0] addr_s2;
    iofl_acc_t acc;
    logic [15:0] data;
    logic oe_n;
    logic clear;
    logic [1:0] settle;
  } iofl_top_state_t;

  typedef struct packed {
    logic [3:0] latched;
    logic [3:0][`IOFL_CNT_W-1:0] on_cnt;
  } iofl_det_state_t;

endpackage : iofl_pkg

// >>> verilog/iofl_fault_if.sv
/*
  Carrier between the I/O top and the fault detector.
  Assumes both ends sit on the same reference clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface iofl_fault_if;
  logic [3:0] pair_on;
  logic [3:0] short_det;
  logic [3:0] open_det;
  logic open_en;
  logic clear;
  logic [3:0] latched;

  modport ctl (
    output pair_on,
    output short_det,
    output open_det,
    output open_en,
    output clear,
    input latched
  );

  modport det (
    input pair_on,
    input short_det,
    input open_det,
    input open_en,
    input clear,
    output latched
  );
endinterface : iofl_fault_if

`default_nettype wire

// >>> verilog/iofl_fault_det.sv
/*
  Per-pair fault latches with switch-on blanking.
  Assumes synchronised sense inputs and a one-cycle clear pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iofl_map.svh"

module iofl_fault_det #(
  parameter int unsigned BLANK_CYCLES = `IOFL_BLANK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  iofl_fault_if.det f
);

  localparam logic [`IOFL_CNT_W-1:0] BLANK_C = `IOFL_CNT_W'(BLANK_CYCLES);

  iofl_pkg::iofl_det_state_t q;
  iofl_pkg::iofl_det_state_t d;
  logic [3:0] ready;
  logic [3:0] qual;
  logic [3:0][`IOFL_CNT_W-1:0] cnt_nxt;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pair
      // Stage needs time to sense a short after switch-on
      assign ready[g] = f.pair_on[g] && (q.on_cnt[g] >= BLANK_C);
      assign cnt_nxt[g] = !f.pair_on[g] ? '0 :
                          (ready[g] ? q.on_cnt[g] : q.on_cnt[g] + `IOFL_CNT_W'(1));
      assign qual[g] = ready[g] && (f.short_det[g] || (f.open_en && f.open_det[g]));
    end
  endgenerate

  always_comb
  begin
    d = q;
    d.on_cnt = cnt_nxt;
    // Set beats clear so no event is lost
    d.latched = (q.latched & ~{4{f.clear}}) | qual;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      // Mirrors the power-up fault state; software must clear
      q.latched <= `IOFL_FAULT_RST;
      q.on_cnt <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign f.latched = q.latched;

  a_latch_sticky: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !f.clear |=> ((q.latched & $past(q.latched)) == $past(q.latched)))
    else $error("fault latch dropped without clear");

  a_clear_all: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (f.clear && qual == 4'h0) |=> (q.latched == 4'h0))
    else $error("clear left a latch set");

  a_blank_min: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ((q.latched & ~$past(q.latched) & ~$past(ready)) == 4'h0))
    else $error("fault latched inside blanking time");

  a_blank_bound: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (|(ready & f.short_det)) |=> ((q.latched & $past(ready & f.short_det)) == $past(ready & f.short_det)))
    else $error("short not latched once blanking ended");

  a_open_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!f.open_en && f.short_det == 4'h0 && !f.clear) |=> (q.latched == $past(q.latched)))
    else $error("open load latched while reporting off");

endmodule : iofl_fault_det

`default_nettype wire

// >>> verilog/iofl_top.sv
/*
  Digital I/O glue between microcontroller port pins and isolated field
  signals, with per-pair short-circuit latches read through a chip-select
  window. Assumes all pins are asynchronous to ref_clk_i and the host adds
  enough wait states to cover the synchroniser latency.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iofl_map.svh"

module iofl_top #(
  parameter int unsigned BLANK_CYCLES = `IOFL_BLANK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [23:0] field_input_lines_i,
  output logic [15:0] mcu_port2_o,
  output logic [3:0] mcu_port5_in_o,
  output logic [3:0] mcu_timer_in_o,
  input wire logic [7:0] mcu_port8_i,
  output logic [7:0] relay_output_lines_o,
  input wire logic [3:0] mcu_port3_lo_i,
  input wire logic [3:0] mcu_port7_hi_i,
  input wire logic [1:0] mcu_port7_pwm_i,
  output logic [7:0] high_side_output_lines_n_o,
  output logic pwm_output_a_n_o,
  output logic pwm_output_b_n_o,
  input wire logic [3:0] pair_short_i,
  input wire logic [3:0] pair_open_load_i,
  input wire logic open_load_report_i,
  output logic [3:0] fault_lamp_o,
  input wire logic io_window_select_n_i,
  input wire logic bus_rd_n_i,
  input wire logic [1:0] bus_addr_i,
  output logic [15:0] bus_data_o,
  output logic bus_data_oe_n_o
);

  localparam iofl_pkg::iofl_top_state_t TOP_RST = '{
    // Sync stages reset to the idle field level so no false port edge follows reset
    fin_s1: `IOFL_FIELD_IDLE,
    fin_s2: `IOFL_FIELD_IDLE,
    fin_q: `IOFL_FIELD_RST,
    rly_s1: `IOFL_RELAY_RST,
    rly_s2: `IOFL_RELAY_RST,
    p3_s1: `IOFL_HS_NIB_RST,
    p3_s2: `IOFL_HS_NIB_RST,
    p7_s1: `IOFL_HS_NIB_RST,
    p7_s2: `IOFL_HS_NIB_RST,
    pwm_s1: `IOFL_PWM_RST,
    pwm_s2: `IOFL_PWM_RST,
    cs_s1: 1'b1,
    cs_s2: 1'b1,
    rd_s1: 1'b1,
    rd_s2: 1'b1,
    acc: iofl_pkg::ACC_IDLE,
    oe_n: 1'b1,
    default: '0
  };

  iofl_pkg::iofl_top_state_t q;
  iofl_pkg::iofl_top_state_t d;
  logic rd_sel;
  logic [7:0] hs_n;
  logic live;

  iofl_fault_if f ();

  iofl_fault_det #(
    .BLANK_CYCLES(BLANK_CYCLES)
  ) u_det (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .f(f)
  );

  assign rd_sel = !q.cs_s2 && !q.rd_s2;
  assign hs_n = {q.p7_s2, q.p3_s2};
  assign live = (q.settle == `IOFL_SETTLE_DONE);

  always_comb
  begin
    d = q;
    // Two-stage synchronisers on every pin; stage one feeds stage two only
    d.fin_s1 = field_input_lines_i;
    d.fin_s2 = q.fin_s1;
    // Energised field input reads as 0 at the port
    d.fin_q = ~q.fin_s2;
    d.rly_s1 = mcu_port8_i;
    d.rly_s2 = q.rly_s1;
    d.p3_s1 = mcu_port3_lo_i;
    d.p3_s2 = q.p3_s1;
    d.p7_s1 = mcu_port7_hi_i;
    d.p7_s2 = q.p7_s1;
    // Sync costs up to 40 ns of edge jitter; fine against a 20 us PWM period
    d.pwm_s1 = mcu_port7_pwm_i;
    d.pwm_s2 = q.pwm_s1;
    d.sc_s1 = pair_short_i;
    d.sc_s2 = q.sc_s1;
    d.ol_s1 = pair_open_load_i;
    d.ol_s2 = q.ol_s1;
    d.olen_s1 = open_load_report_i;
    d.olen_s2 = q.olen_s1;
    d.cs_s1 = io_window_select_n_i;
    d.cs_s2 = q.cs_s1;
    d.rd_s1 = bus_rd_n_i;
    d.rd_s2 = q.rd_s1;
    d.addr_s1 = bus_addr_i;
    d.addr_s2 = q.addr_s1;
    d.settle = live ? q.settle : q.settle + 2'h1;
    d.clear = 1'b0;

    unique case (q.acc)
      iofl_pkg::ACC_IDLE:
      begin
        if (rd_sel)
        begin
          if (q.addr_s2 == `IOFL_OFS_FAULT_STATUS)
          begin
            // Snapshot taken once; later faults show on the next read
            d.acc = iofl_pkg::ACC_STATUS;
            d.data = {12'h000, ~f.latched};
            d.oe_n = 1'b0;
          end
          else if (q.addr_s2 == `IOFL_OFS_FAULT_CLEAR)
          begin
            d.acc = iofl_pkg::ACC_CLEAR;
            d.data = {12'h000, ~f.latched};
            d.oe_n = 1'b0;
            d.clear = 1'b1;
          end
          else
          begin
            d.acc = iofl_pkg::ACC_OTHER;
          end
        end
      end
      iofl_pkg::ACC_STATUS,
      iofl_pkg::ACC_CLEAR,
      iofl_pkg::ACC_OTHER:
      begin
        // One clear per strobe, however long the host holds it
        if (!rd_sel)
        begin
          d.acc = iofl_pkg::ACC_IDLE;
          d.oe_n = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      q <= TOP_RST;
    end
    else
    begin
      q <= d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pair
      // Pair g covers high-side outputs 2g and 2g+1
      assign f.pair_on[g] = !(hs_n[2*g] && hs_n[2*g+1]);
    end
  endgenerate

  assign f.short_det = q.sc_s2;
  assign f.open_det = q.ol_s2;
  assign f.open_en = q.olen_s2;
  assign f.clear = q.clear;

  assign mcu_port2_o = q.fin_q[15:0];
  assign mcu_port5_in_o = q.fin_q[19:16];
  assign mcu_timer_in_o = q.fin_q[23:20];
  assign relay_output_lines_o = q.rly_s2;
  assign high_side_output_lines_n_o = hs_n;
  assign pwm_output_a_n_o = q.pwm_s2[0];
  assign pwm_output_b_n_o = q.pwm_s2[1];
  assign fault_lamp_o = f.latched;
  assign bus_data_o = q.data;
  assign bus_data_oe_n_o = q.oe_n;

  sequence s_status_start;
    q.acc == iofl_pkg::ACC_IDLE && rd_sel && q.addr_s2 == `IOFL_OFS_FAULT_STATUS;
  endsequence

  sequence s_clear_start;
    q.acc == iofl_pkg::ACC_IDLE && rd_sel && q.addr_s2 == `IOFL_OFS_FAULT_CLEAR;
  endsequence

  sequence s_one_clear;
    f.clear ##1 !f.clear;
  endsequence

  a_input_invert: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    live && $past(live, 3) |-> (mcu_port2_o == ~$past(field_input_lines_i[15:0], 3)))
    else $error("port 2 inputs not inverted field lines");

  a_timer_map: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    live && $past(live, 3) |-> (mcu_timer_in_o == ~$past(field_input_lines_i[23:20], 3)))
    else $error("timer inputs wrong");

  a_relay_map: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    live |-> (relay_output_lines_o == $past(mcu_port8_i, `IOFL_SYNC_LAT)))
    else $error("relay outputs not following port 8");

  a_high_side_map: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    live |-> (high_side_output_lines_n_o ==
              {$past(mcu_port7_hi_i, `IOFL_SYNC_LAT), $past(mcu_port3_lo_i, `IOFL_SYNC_LAT)}))
    else $error("high-side outputs mapped wrong");

  a_pwm_map: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    live |-> ({pwm_output_b_n_o, pwm_output_a_n_o} == $past(mcu_port7_pwm_i, `IOFL_SYNC_LAT)))
    else $error("pwm outputs mapped wrong");

  a_status_read: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_status_start |=> (!bus_data_oe_n_o && bus_data_o == {12'h000, ~$past(f.latched)}))
    else $error("status read returned wrong data");

  a_clear_read: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_clear_start |=> s_one_clear)
    else $error("clear read did not pulse clear once");

  a_status_quiet: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_status_start |=> !f.clear [*2])
    else $error("status read caused a clear");

  a_lamp_match: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_status_start |=> (bus_data_o[`IOFL_FAULT_MSB:`IOFL_FAULT_LSB] == ~$past(fault_lamp_o)))
    else $error("lamps disagree with status");

  a_bus_release: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (q.acc != iofl_pkg::ACC_IDLE && !rd_sel) |=> bus_data_oe_n_o)
    else $error("data bus held after strobe end");

endmodule : iofl_top

`default_nettype wire

// >>> verification/iofl_host_model.sv
/*
  Host side of the fault latch: the chip-select read cycle.
  Assumes the testbench calls read_word and drives the port pins itself.
*/
`timescale 1ns/1ps
`default_nettype none

module iofl_host_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] data_i,
  input wire logic oe_n_i,
  output logic sel_n_o,
  output logic rd_n_o,
  output logic [1:0] addr_o
);
  initial
  begin
    sel_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = 2'h0;
  end

  // Strobes held six cycles so the slow synchroniser always answers
  task automatic read_word(input logic [1:0] ofs, output logic [15:0] data, output logic got);
    int n;
    got = 1'b0;
    data = 16'h0000;
    @(posedge ref_clk_i);
    #1;
    sel_n_o = 1'b0;
    rd_n_o = 1'b0;
    addr_o = ofs;
    for (n = 0; n < 6; n++)
    begin
      @(posedge ref_clk_i);
      #1;
      if (oe_n_i === 1'b0 && !got)
      begin
        got = 1'b1;
        data = data_i;
      end
    end
    sel_n_o = 1'b1;
    rd_n_o = 1'b1;
    // Deselected address is not held, so stale offsets cannot pass
    addr_o = ~ofs;
    repeat (4) @(posedge ref_clk_i);
    // Return off the edge so the caller's next stimulus does not race it
    #1;
  endtask : read_word
endmodule : iofl_host_model

`default_nettype wire

// >>> verification/tb_iofl_top.sv
/*
  Self-checking bench for the I/O fault latch top.
  Assumes iofl_host_model performs all window reads.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_iofl_top;
  logic ref_clk_i, srst_i;
  logic [23:0] field;
  logic [15:0] port2;
  logic [3:0] port5, timer_in, pair_short, pair_open, lamps;
  logic [7:0] port8, relays, hs_pin, hs_n;
  logic [1:0] pwm_pin, addr;
  logic pwm_a_n, pwm_b_n, ol_report, sel_n, rd_n, oe_n, got;
  logic [15:0] bus_data, rdata;
  int mismatches, n_checks, cycles, k;

  iofl_top #(.BLANK_CYCLES(8)) u_dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .field_input_lines_i(field), .mcu_port2_o(port2),
    .mcu_port5_in_o(port5), .mcu_timer_in_o(timer_in),
    .mcu_port8_i(port8), .relay_output_lines_o(relays),
    .mcu_port3_lo_i(hs_pin[3:0]), .mcu_port7_hi_i(hs_pin[7:4]),
    .mcu_port7_pwm_i(pwm_pin), .high_side_output_lines_n_o(hs_n),
    .pwm_output_a_n_o(pwm_a_n), .pwm_output_b_n_o(pwm_b_n),
    .pair_short_i(pair_short), .pair_open_load_i(pair_open),
    .open_load_report_i(ol_report), .fault_lamp_o(lamps),
    .io_window_select_n_i(sel_n), .bus_rd_n_i(rd_n), .bus_addr_i(addr),
    .bus_data_o(bus_data), .bus_data_oe_n_o(oe_n)
  );

  iofl_host_model u_host (
    .ref_clk_i(ref_clk_i), .data_i(bus_data), .oe_n_i(oe_n),
    .sel_n_o(sel_n), .rd_n_o(rd_n), .addr_o(addr)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic read_chk(input logic [1:0] ofs, input logic [15:0] exp);
    u_host.read_word(ofs, rdata, got);
    check("read_got", {23'h0, got}, 24'h00_0001);
    check("read_data", {8'h0, rdata}, {8'h0, exp});
  endtask : read_chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Run takes about 515 cycles; ceiling leaves wide margin
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    srst_i = 1'b1;
    field = 24'h00_0000;
    port8 = 8'h00;
    hs_pin = 8'hff;
    pwm_pin = 2'h3;
    pair_short = 4'h0;
    pair_open = 4'h0;
    ol_report = 1'b0;
    tick(2);
    srst_i = 1'b0;
    tick(4);
    check("relays_rst", {16'h0, relays}, 24'h00_0000);
    check("hs_rst", {16'h0, hs_n}, 24'h00_00ff);
    check("lamps_rst", {20'h0, lamps}, 24'h00_000f);
    read_chk(2'h2, 16'h0000);
    read_chk(2'h3, 16'h0000);
    read_chk(2'h2, 16'h000f);
    // Pin routing with two complementary patterns
    for (k = 0; k < 2; k++)
    begin
      field = k ? 24'ha5_3c5a : 24'h5a_c3a5;
      port8 = k ? 8'h69 : 8'h96;
      hs_pin = k ? 8'h3c : 8'hc3;
      pwm_pin = k[0] ? 2'h1 : 2'h2;
      tick(4);
      check("port2", {8'h0, port2}, {8'h0, ~field[15:0]});
      check("port5", {20'h0, port5}, {20'h0, ~field[19:16]});
      check("timer_in", {20'h0, timer_in}, {20'h0, ~field[23:20]});
      check("relays", {16'h0, relays}, {16'h0, port8});
      check("hs_n", {16'h0, hs_n}, {16'h0, hs_pin});
      check("pwm", {22'h0, pwm_b_n, pwm_a_n}, {22'h0, pwm_pin});
    end
    hs_pin = 8'hff;
    tick(4);
    read_chk(2'h3, 16'h000f);
    // Shorts on every pair, one pair switched on at a time
    for (k = 0; k < 4; k++)
    begin
      hs_pin = ~(8'h03 << (2 * k));
      pair_short = 4'hf;
      tick(6);
      check("lamps_blank", {20'h0, lamps}, 24'h00_0000);
      tick(24);
      check("lamps_set", {20'h0, lamps}, {20'h0, 4'h1 << k});
      read_chk(2'h2, {12'h0, ~(4'h1 << k)});
      pair_short = 4'h0;
      tick(4);
      read_chk(2'h2, {12'h0, ~(4'h1 << k)});
      read_chk(2'h3, {12'h0, ~(4'h1 << k)});
      read_chk(2'h2, 16'h000f);
      check("lamps_clr", {20'h0, lamps}, 24'h00_0000);
      hs_pin = 8'hff;
      tick(4);
    end
    // Unmapped offsets never drive the bus
    u_host.read_word(2'h0, rdata, got);
    check("ofs0_drive", {23'h0, got}, 24'h00_0000);
    u_host.read_word(2'h1, rdata, got);
    check("ofs1_drive", {23'h0, got}, 24'h00_0000);
    // Open load counts only while open-load reporting is on
    hs_pin = 8'hfc;
    pair_open = 4'h1;
    tick(30);
    check("open_off", {20'h0, lamps}, 24'h00_0000);
    ol_report = 1'b1;
    tick(30);
    check("open_on", {20'h0, lamps}, 24'h00_0001);
    pair_open = 4'h0;
    tick(4);
    read_chk(2'h3, 16'h000e);
    check("open_clr", {20'h0, lamps}, 24'h00_0000);
    // Mid-run reset brings back the all-faulted power-up state
    srst_i = 1'b1;
    tick(2);
    srst_i = 1'b0;
    tick(4);
    check("lamps_rst2", {20'h0, lamps}, 24'h00_000f);
    read_chk(2'h2, 16'h0000);
    read_chk(2'h3, 16'h0000);
    check("lamps_clr2", {20'h0, lamps}, 24'h00_0000);
    print_verdict();
  end
endmodule : tb_iofl_top

`default_nettype wire
